// file: frrc_fault_recovery_reset_ctrl.sv
/*
  Fault recovery sequencer control and system reset output.
  Assumes monitor comparator flags, slot-12 assignment and slot-delay expiry come from the
  sequencer; configuration bytes are written by the storage loader on the documented port.
*/
`timescale 1ns/100ps
`default_nettype none
module frrc_fault_recovery_reset_ctrl #(
  parameter int unsigned RAILS = 12
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             cfg_we,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [7:0]       cfg_wdata,
  output var  logic [7:0]       cfg_rdata,
  input  wire logic [1:0]       fault_log_mode,
  input  wire logic             enable_in,
  input  wire logic             soft_enable_n,
  input  wire logic             critical_fault,
  input  wire logic [RAILS-1:0] crit_enabled,
  input  wire logic [RAILS-1:0] rail_uv,
  input  wire logic [RAILS-1:0] rail_ov,
  input  wire logic [RAILS-1:0] rail_ew,
  input  wire logic [RAILS-1:0] slot12_assigned,
  input  wire logic             slot_delay_done,
  input  wire logic             power_down,
  input  wire logic             general_pin_four_is_mr,
  input  wire logic             manual_reset_in,
  output var  logic             seq_start,
  output var  logic             enables_on,
  output var  logic             reset_active,
  output var  logic [2:0]       state_o,
  output var  logic             reset_pin_o,
  output var  logic             reset_pin_oe
);
  initial begin
    if (RAILS < 1 || RAILS > 12) $error("RAILS must be 1 to 12");
  end

  typedef logic [frrc_pkg::CNT_W-1:0] frrc_cnt_t;

  function automatic frrc_cnt_t frrc_cycles(input int unsigned us);
    int unsigned c;
    c = us * frrc_pkg::US_CYC;
    if (c < 1) c = 1;
    return frrc_cnt_t'(c);
  endfunction

  // Synchronised reset
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Configuration registers
  logic [7:0] reset_output_config;
  logic [7:0] reset_rail_select_low;
  logic [7:0] reset_rail_select_high;
  logic [7:0] fault_recovery_config;
  logic [7:0] next_roc;
  logic [7:0] next_rsl;
  logic [7:0] next_rsh;
  logic [7:0] next_frc;
  logic [7:0] next_rdata;

  always_comb begin
    next_roc = reset_output_config;
    next_rsl = reset_rail_select_low;
    next_rsh = reset_rail_select_high;
    next_frc = fault_recovery_config;
    if (cfg_we) begin
      unique case (cfg_addr)
        frrc_pkg::REG_RESET_OUTPUT_CONFIG:    next_roc = {1'b0, cfg_wdata[6:0]};
        frrc_pkg::REG_RESET_RAIL_SELECT_LOW:  next_rsl = cfg_wdata;
        frrc_pkg::REG_RESET_RAIL_SELECT_HIGH: next_rsh = cfg_wdata & frrc_pkg::RAIL_HIGH_MASK;
        frrc_pkg::REG_FAULT_RECOVERY_CONFIG:  next_frc = cfg_wdata;
        default: ;
      endcase
    end
    unique case (cfg_addr)
      frrc_pkg::REG_RESET_OUTPUT_CONFIG:    next_rdata = reset_output_config;
      frrc_pkg::REG_RESET_RAIL_SELECT_LOW:  next_rdata = reset_rail_select_low;
      frrc_pkg::REG_RESET_RAIL_SELECT_HIGH: next_rdata = reset_rail_select_high;
      frrc_pkg::REG_FAULT_RECOVERY_CONFIG:  next_rdata = fault_recovery_config;
      default:                              next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reset_output_config    <= 8'h00;
      reset_rail_select_low  <= 8'h00;
      reset_rail_select_high <= 8'h00;
      fault_recovery_config  <= 8'h00;
      cfg_rdata              <= 8'h00;
    end else if (ce) begin
      reset_output_config    <= next_roc;
      reset_rail_select_low  <= next_rsl;
      reset_rail_select_high <= next_rsh;
      fault_recovery_config  <= next_frc;
      cfg_rdata              <= next_rdata;
    end
  end

  // Field decode
  logic [1:0]       rst_cond;
  logic [2:0]       rst_tmo_sel;
  logic [2:0]       retry_sel;
  logic             latch_mode;
  logic [11:0]      dep_all;
  logic [RAILS-1:0] watched;
  logic [RAILS-1:0] rail_fault;
  logic             rail_reset;
  logic             seq_fault;
  logic             mr_active;
  logic             pwr_done;

  always_comb begin
    rst_cond    = reset_output_config[frrc_pkg::RST_COND_LSB +: 2];
    rst_tmo_sel = reset_output_config[frrc_pkg::RST_TMO_LSB +: 3];
    retry_sel   = fault_recovery_config[frrc_pkg::FR_DELAY_LSB +: 3];
    latch_mode  = fault_recovery_config[frrc_pkg::FR_MODE_BIT];
    dep_all     = {reset_rail_select_high[3:0], reset_rail_select_low};
    watched     = dep_all[RAILS-1:0] | crit_enabled;
    unique case (rst_cond)
      frrc_pkg::COND_UV: rail_fault = rail_uv;
      frrc_pkg::COND_EW: rail_fault = rail_ew;
      frrc_pkg::COND_OV: rail_fault = rail_ov;
      frrc_pkg::COND_UO: rail_fault = rail_uv | rail_ov;
    endcase
    rail_reset = |(rail_fault & watched);
    seq_fault  = |(rail_uv | rail_ov);
    mr_active  = general_pin_four_is_mr & ~manual_reset_in;
    if (|slot12_assigned) begin
      pwr_done = &(~rail_uv | ~slot12_assigned);
    end else begin
      pwr_done = slot_delay_done;
    end
  end

  // Sequencer control
  frrc_pkg::frrc_state_t state;
  frrc_pkg::frrc_state_t next_state;
  frrc_cnt_t             cnt;
  frrc_cnt_t             next_cnt;
  logic                  en_q;
  logic                  soft_q;
  logic                  next_seq_start;
  logic                  next_enables_on;
  logic                  next_reset_active;
  logic                  go;
  frrc_cnt_t             retry_wait;

  always_comb begin
    go         = enable_in & ~soft_enable_n;
    retry_wait = frrc_cycles(frrc_pkg::ARD_US[retry_sel]);
    // Honour fault-log storing time before a retry restart; a restart out of the latch is not delayed
    if (frrc_cycles(frrc_pkg::LOG_US[fault_log_mode]) > retry_wait &&
        fault_log_mode != frrc_pkg::LOG_NONE) begin
      retry_wait = frrc_cycles(frrc_pkg::LOG_US[fault_log_mode]);
    end
    next_state     = state;
    next_cnt       = cnt;
    next_seq_start = 1'b0;
    unique case (state)
      frrc_pkg::FRRC_OFF: begin
        if (go) begin
          next_state     = frrc_pkg::FRRC_SEQ;
          next_seq_start = 1'b1;
        end
      end
      frrc_pkg::FRRC_SEQ: begin
        if (!go) begin
          next_state = frrc_pkg::FRRC_OFF;
        end else if (seq_fault || critical_fault) begin
          next_state = latch_mode ? frrc_pkg::FRRC_LATCHED : frrc_pkg::FRRC_RETRY;
          next_cnt   = retry_wait;
        end else if (pwr_done) begin
          next_state = frrc_pkg::FRRC_HOLD;
          next_cnt   = frrc_cycles(frrc_pkg::RTO_US[rst_tmo_sel]);
        end
      end
      frrc_pkg::FRRC_HOLD, frrc_pkg::FRRC_RUN: begin
        if (!go) begin
          next_state = frrc_pkg::FRRC_OFF;
        end else if (critical_fault) begin
          next_state = latch_mode ? frrc_pkg::FRRC_LATCHED : frrc_pkg::FRRC_RETRY;
          next_cnt   = retry_wait;
        end else if (state == frrc_pkg::FRRC_HOLD) begin
          if (cnt <= frrc_cnt_t'(1)) begin
            next_state = frrc_pkg::FRRC_RUN;
          end else begin
            next_cnt = cnt - frrc_cnt_t'(1);
          end
        end
      end
      frrc_pkg::FRRC_RETRY: begin
        if (!go) begin
          next_state = frrc_pkg::FRRC_OFF;
        end else if (cnt <= frrc_cnt_t'(1)) begin
          next_state     = frrc_pkg::FRRC_SEQ;
          next_seq_start = 1'b1;
        end else begin
          next_cnt = cnt - frrc_cnt_t'(1);
        end
      end
      frrc_pkg::FRRC_LATCHED: begin
        // An enable falling, software enable rewritten, or go low (enable_in low or soft_enable_n high) frees the latch
        if ((en_q && !enable_in) || (soft_enable_n == 1'b0 && soft_q == 1'b1) ||
            !go) begin
          next_state = frrc_pkg::FRRC_OFF;
        end
      end
      default: next_state = frrc_pkg::FRRC_OFF;
    endcase
    next_enables_on   = (next_state == frrc_pkg::FRRC_SEQ) ||
                        (next_state == frrc_pkg::FRRC_HOLD) ||
                        (next_state == frrc_pkg::FRRC_RUN);
    next_reset_active = (next_state != frrc_pkg::FRRC_RUN) || power_down ||
                        rail_reset || mr_active;
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state        <= frrc_pkg::FRRC_OFF;
      cnt          <= '0;
      en_q         <= 1'b0;
      soft_q       <= 1'b1;
      seq_start    <= 1'b0;
      enables_on   <= 1'b0;
      reset_active <= 1'b1;
      state_o      <= 3'h0;
    end else if (ce) begin
      state        <= next_state;
      cnt          <= next_cnt;
      en_q         <= enable_in;
      soft_q       <= soft_enable_n;
      seq_start    <= next_seq_start;
      enables_on   <= next_enables_on;
      reset_active <= next_reset_active;
      state_o      <= next_state;
    end
  end

  frrc_reset_pin u_pin (
    .clk         (clk),
    .rst_n       (rst_sync),
    .ce          (ce),
    .assert_in   (next_reset_active),
    .active_high (reset_output_config[frrc_pkg::RST_POL_BIT]),
    .push_pull   (reset_output_config[frrc_pkg::RST_DRIVE_BIT]),
    .pin_o       (reset_pin_o),
    .pin_oe      (reset_pin_oe)
  );
endmodule
`default_nettype wire

// file: frrc_fault_recovery_reset_ctrl_asserts.sv
/*
  Port checker for the fault recovery and reset controller.
  Assumes it is bound to the top module; shadows the two config bytes from writes.
*/
`timescale 1ns/100ps
`default_nettype none
module frrc_asserts #(
  parameter int unsigned RAILS = 12
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic             cfg_we,
  input wire logic [7:0]       cfg_addr,
  input wire logic [7:0]       cfg_wdata,
  input wire logic             enable_in,
  input wire logic             soft_enable_n,
  input wire logic             critical_fault,
  input wire logic [RAILS-1:0] rail_uv,
  input wire logic [RAILS-1:0] rail_ov,
  input wire logic             general_pin_four_is_mr,
  input wire logic             manual_reset_in,
  input wire logic             seq_start,
  input wire logic             enables_on,
  input wire logic             reset_active,
  input wire logic [2:0]       state_o,
  input wire logic             reset_pin_o,
  input wire logic             reset_pin_oe
);
  logic [7:0] oc;
  logic [7:0] fr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc <= 8'h00;
      fr <= 8'h00;
    end else if (ce && cfg_we) begin
      if (cfg_addr == 8'h19) oc <= cfg_wdata;
      if (cfg_addr == 8'h4f) fr <= cfg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_run_fault;
    ce && critical_fault && state_o == frrc_pkg::FRRC_RUN && enable_in && !soft_enable_n;
  endsequence
  a_pin_level: assert property (!$past(cfg_we) && reset_pin_oe |->
    reset_pin_o == (reset_active == oc[2])) else $error("reset pin level wrong");
  a_open_drain: assert property (!$past(cfg_we) && !oc[3] && !reset_active |->
    !reset_pin_oe) else $error("open drain pin driven while idle");
  a_push_pull: assert property (!$past(cfg_we) && oc[3] |-> reset_pin_oe)
    else $error("push pull pin not driven");
  a_reset_seq: assert property (state_o inside {frrc_pkg::FRRC_SEQ,
    frrc_pkg::FRRC_HOLD, frrc_pkg::FRRC_RETRY} |-> reset_active) else $error("reset idle");
  a_fault_latch: assert property (s_run_fault ##0 fr[3] |=>
    state_o == frrc_pkg::FRRC_LATCHED && !enables_on) else $error("no latch off");
  a_fault_retry: assert property (s_run_fault ##0 !fr[3] |=>
    state_o == frrc_pkg::FRRC_RETRY && !enables_on) else $error("no retry");
  a_start_pulse: assert property (seq_start |-> state_o == frrc_pkg::FRRC_SEQ
    ##1 !seq_start) else $error("start pulse wrong");
  a_seq_rail: assert property (ce && state_o == frrc_pkg::FRRC_SEQ && (|rail_ov ||
    |rail_uv) && enable_in && !soft_enable_n |=> !enables_on) else $error("rail fault kept");
  a_manual_reset: assert property (ce && general_pin_four_is_mr && !manual_reset_in
    |-> ##[1:2] reset_active) else $error("manual reset ignored");
endmodule
bind frrc_fault_recovery_reset_ctrl frrc_asserts #(.RAILS(RAILS)) u_asserts (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .enable_in(enable_in), .soft_enable_n(soft_enable_n),
  .critical_fault(critical_fault), .rail_uv(rail_uv), .rail_ov(rail_ov),
  .general_pin_four_is_mr(general_pin_four_is_mr), .manual_reset_in(manual_reset_in),
  .seq_start(seq_start), .enables_on(enables_on), .reset_active(reset_active),
  .state_o(state_o), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe));
`default_nettype wire

// file: frrc_fault_recovery_reset_ctrl_test.sv
/*
  Self-checking bench: registers, power-up, reset conditions, retry and latch-off.
  Assumes the supply and host model at the far side and a 10 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module frrc_fault_recovery_reset_ctrl_test;
  localparam logic [7:0] ADR [4] = '{8'h19, 8'h1a, 8'h1b, 8'h4f};
  localparam logic [7:0] MSK [4] = '{8'h7f, 8'hff, 8'h0f, 8'hff};
  logic clk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, enable_in = 1'b0, soft_enable_n = 1'b1;
  logic critical_fault = 1'b0, general_pin_four_is_mr = 1'b0, manual_reset_in = 1'b1;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  logic [1:0] fault_log_mode = 2'h3;
  logic [11:0] crit_enabled = '0, rail_uv = '0, rail_ov = '0, rail_ew = '0;
  wire logic [7:0] cfg_rdata;
  wire logic [2:0] state_o;
  wire logic seq_start, enables_on, reset_active, reset_pin_o, reset_pin_oe;
  wire logic slot_delay_done, reset_level;
  int num_errors = 0, total_checks = 0, seed = 71;
  always #50 clk = ~clk;
  frrc_fault_recovery_reset_ctrl #(.RAILS(12)) uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .fault_log_mode(fault_log_mode), .enable_in(enable_in), .soft_enable_n(soft_enable_n),
    .critical_fault(critical_fault), .crit_enabled(crit_enabled), .rail_uv(rail_uv),
    .rail_ov(rail_ov), .rail_ew(rail_ew), .slot12_assigned(12'h000),
    .slot_delay_done(slot_delay_done), .power_down(1'b0),
    .general_pin_four_is_mr(general_pin_four_is_mr), .manual_reset_in(manual_reset_in),
    .seq_start(seq_start), .enables_on(enables_on), .reset_active(reset_active),
    .state_o(state_o), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe));
  frrc_supply_host #(.RAMP(20)) u_far (.clk(clk), .enables_on(enables_on),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
    .slot_delay_done(slot_delay_done), .reset_level(reset_level));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfg_addr <= a;
    @(posedge clk);
    #1 chk("cfg_rdata", cfg_rdata, exp);
  endtask
  task automatic wait_st(input logic [2:0] s, output int n);
    n = 0;
    while (state_o !== s && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("state_o", state_o, s);
  endtask
  // Reset level expected for condition code c and flag f (0 under, 1 warning, 2 over)
  function automatic logic exp_rst(input logic [1:0] c, input int f);
    case (c)
      2'h0: return f == 0;
      2'h1: return f == 1;
      2'h2: return f == 2;
      default: return f != 1;
    endcase
  endfunction
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial begin
    int n;
    logic [7:0] r;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("reset_active", reset_active, 1'b1);
    foreach (ADR[i]) begin
      rd(ADR[i], 8'h00);
      r = $random(seed);
      wr(ADR[i], r);
      rd(ADR[i], r & MSK[i]);
    end
    rd(8'h20, 8'h00);
    foreach (ADR[i]) wr(ADR[i], 8'h00);
    chk("reset_level", reset_level, 1'b0);
    enable_in <= 1'b1;
    soft_enable_n <= 1'b0;
    wait_st(frrc_pkg::FRRC_SEQ, n);
    chk("enables_on", enables_on, 1'b1);
    wait_st(frrc_pkg::FRRC_HOLD, n);
    wait_st(frrc_pkg::FRRC_RUN, n);
    chk("hold_cycles", n inside {[249:251]}, 1'b1);
    chk("reset_level", reset_level, 1'b1);
    wr(8'h1b, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(8'h19, 8'h0c | c[7:0]);
      for (int f = 0; f < 3; f++) begin
        rail_uv[9] <= f == 0;
        rail_ew <= {2'b00, f == 1, 9'($random(seed))};
        rail_ov[9] <= f == 2;
        repeat (3) @(posedge clk);
        #1 chk("reset_level", reset_level, exp_rst(c[1:0], f));
        @(posedge clk);
        {rail_uv, rail_ew, rail_ov} <= '0;
        repeat (300) @(posedge clk);
        #1 chk("reset_active", reset_active, 1'b0);
      end
    end
    crit_enabled[2] <= 1'b1;
    rail_uv[2] <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("reset_level", reset_level, 1'b1);
    rail_uv[2] <= 1'b0;
    manual_reset_in <= 1'b0;
    repeat (300) @(posedge clk);
    #1 chk("reset_level", reset_level, 1'b0);
    general_pin_four_is_mr <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("reset_level", reset_level, 1'b1);
    manual_reset_in <= 1'b1;
    repeat (300) @(posedge clk);
    // No log stored, so the shortest retry delay is safe
    fault_log_mode <= 2'h3;
    critical_fault <= 1'b1;
    wait_st(frrc_pkg::FRRC_RETRY, n);
    chk("enables_on", enables_on, 1'b0);
    @(posedge clk);
    critical_fault <= 1'b0;
    wait_st(frrc_pkg::FRRC_SEQ, n);
    chk("seq_start", seq_start, 1'b1);
    chk("retry_cycles", n inside {[197:201]}, 1'b1);
    wait_st(frrc_pkg::FRRC_RUN, n);
    wr(8'h4f, 8'h08);
    critical_fault <= 1'b1;
    wait_st(frrc_pkg::FRRC_LATCHED, n);
    @(posedge clk);
    critical_fault <= 1'b0;
    repeat (400) @(posedge clk);
    #1 chk("state_o", state_o, frrc_pkg::FRRC_LATCHED);
    chk("enables_on", enables_on, 1'b0);
    @(posedge clk);
    soft_enable_n <= 1'b1;
    @(posedge clk);
    soft_enable_n <= 1'b0;
    wait_st(frrc_pkg::FRRC_SEQ, n);
    rail_ov[0] <= 1'b1;
    wait_st(frrc_pkg::FRRC_LATCHED, n);
    chk("enables_on", enables_on, 1'b0);
    rail_ov[0] <= 1'b0;
    enable_in <= 1'b0;
    @(posedge clk);
    enable_in <= 1'b1;
    wait_st(frrc_pkg::FRRC_RUN, n);
    stop_test;
  end
endmodule
`default_nettype wire

// file: frrc_pkg.sv
/*
  Constants, register layout and timing for the fault recovery and reset controller.
  Assumes a 10 MHz system clock; configuration bytes arrive already loaded from storage.
*/
`default_nettype none
package frrc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam logic [7:0] REG_RESET_OUTPUT_CONFIG     = 8'h19;
  localparam logic [7:0] REG_RESET_RAIL_SELECT_LOW   = 8'h1a;
  localparam logic [7:0] REG_RESET_RAIL_SELECT_HIGH  = 8'h1b;
  localparam logic [7:0] REG_FAULT_RECOVERY_CONFIG   = 8'h4f;
  localparam int unsigned RST_COND_LSB  = 0;
  localparam int unsigned RST_POL_BIT   = 2;
  localparam int unsigned RST_DRIVE_BIT = 3;
  localparam int unsigned RST_TMO_LSB   = 4;
  localparam int unsigned FR_DELAY_LSB  = 0;
  localparam int unsigned FR_MODE_BIT   = 3;
  localparam logic [1:0] COND_UV = 2'h0;
  localparam logic [1:0] COND_EW = 2'h1;
  localparam logic [1:0] COND_OV = 2'h2;
  localparam logic [1:0] COND_UO = 2'h3;
  localparam logic [1:0] LOG_ALL   = 2'h0;
  localparam logic [1:0] LOG_LINES = 2'h1;
  localparam logic [1:0] LOG_ADC   = 2'h2;
  localparam logic [1:0] LOG_NONE  = 2'h3;
  localparam logic [7:0] RAIL_HIGH_MASK = 8'h0f;
  // Times in microseconds, cycle counts derived from the clock rate
  localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
  localparam int unsigned ARD_US [8] = '{20, 18_750, 37_500, 75_000, 150_000, 300_000,
                                        600_000, 2_400_000};
  localparam int unsigned RTO_US [8] = '{25, 3_000, 37_500, 150_000, 300_000, 600_000,
                                        1_200_000, 2_400_000};
  localparam int unsigned LOG_US [4] = '{306_000, 90_000, 252_000, 0};
  localparam int unsigned CNT_W = 25;
  typedef enum logic [2:0] {
    FRRC_OFF     = 3'b000,
    FRRC_SEQ     = 3'b001,
    FRRC_HOLD    = 3'b011,
    FRRC_RUN     = 3'b010,
    FRRC_RETRY   = 3'b110,
    FRRC_LATCHED = 3'b111
  } frrc_state_t;
endpackage
`default_nettype wire

// file: frrc_reset_pin.sv
/*
  Reset pin driver: polarity and open-drain or push-pull drive from a logical assert.
  Assumes the surrounding wire resolves level from the enable.
*/
`timescale 1ns/100ps
`default_nettype none
module frrc_reset_pin (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic assert_in,
  input  wire logic active_high,
  input  wire logic push_pull,
  output var  logic pin_o,
  output var  logic pin_oe
);
  logic next_pin_o;
  logic next_pin_oe;
  always_comb begin
    next_pin_o  = assert_in ? active_high : ~active_high;
    next_pin_oe = push_pull | assert_in;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b1;
    end else if (ce) begin
      pin_o  <= next_pin_o;
      pin_oe <= next_pin_oe;
    end
  end
endmodule
`default_nettype wire

// file: frrc_supply_host.sv
/*
  Far side model: supply rails that ramp after enable, and the host reset line.
  Assumes the reset line has a pull-up; rails report the slot delay after RAMP cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module frrc_supply_host #(
  parameter int unsigned RAMP = 20
) (
  input  wire logic clk,
  input  wire logic enables_on,
  input  wire logic reset_pin_o,
  input  wire logic reset_pin_oe,
  output var  logic slot_delay_done,
  output var  logic reset_level
);
  int unsigned ramp_cnt;
  // Pull-up holds the line whenever the pin lets go
  assign reset_level = reset_pin_oe ? reset_pin_o : 1'b1;
  always_ff @(posedge clk) begin
    ramp_cnt <= !enables_on ? 0 : (ramp_cnt < RAMP ? ramp_cnt + 1 : ramp_cnt);
  end
  assign slot_delay_done = enables_on && ramp_cnt == RAMP;
endmodule
`default_nettype wire
